// ---- hw/ppc_pkg.sv ----
// Package: constants and types of the pin configuration and cap programmer
package ppc_pkg;

  // ----------------------------------------------------------------
  // Emulation configuration register layout
  // ----------------------------------------------------------------
  localparam int          EMU_EN_BIT   = 7;
  localparam int          EMU_CFG_HI   = 6;
  localparam int          EMU_CFG_LO   = 0;
  localparam logic [7:0]  EMU_CFG_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Capacitor field of the first configuration register
  // ----------------------------------------------------------------
  localparam int          CAP_W        = 5;
  localparam int          CAPREG_HI    = 4;
  localparam int          CAPREG_LO    = 0;
  localparam logic [4:0]  CAPREG_RST   = 5'h00;
  localparam logic [4:0]  CAP_ZERO     = 5'h00;
  localparam int          PULSE_MIN    = 1;
  localparam int          PULSE_MAX    = 32;

  // ----------------------------------------------------------------
  // Output power attenuation, dB below maximum
  // ----------------------------------------------------------------
  localparam logic [3:0]  ATTEN_00     = 4'h0;
  localparam logic [3:0]  ATTEN_01     = 4'h3;
  localparam logic [3:0]  ATTEN_10     = 4'h6;
  localparam logic [3:0]  ATTEN_11     = 4'hA;

  // ----------------------------------------------------------------
  // FSK deviation, kHz either side of the carrier
  // ----------------------------------------------------------------
  localparam logic [5:0]  DEV_LOW_KHZ  = 6'h10;
  localparam logic [5:0]  DEV_HIGH_KHZ = 6'h32;

  // ----------------------------------------------------------------
  // Divide ratios, scaled by 100000
  // ----------------------------------------------------------------
  localparam logic [23:0] DIV_SERIAL   = 24'h000000;
  localparam logic [23:0] DIV_001      = 24'h1E0A6E; // 19.68750
  localparam logic [23:0] DIV_010      = 24'h295A6D; // 27.10125
  localparam logic [23:0] DIV_011      = 24'h25317C; // 24.37500
  localparam logic [23:0] DIV_100      = 24'h27DD14; // 26.12500
  localparam logic [23:0] DIV_101      = 24'h237A08; // 23.25000
  localparam logic [23:0] DIV_110      = 24'h20E6DA; // 21.56250
  localparam logic [23:0] DIV_111      = 24'h2961C0; // 27.12000

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Same bit order as emulation register bits 6:0
  typedef struct packed {
    logic       modFsk;
    logic [1:0] pwr;
    logic       devHigh;
    logic [2:0] freq;
  } ppc_cfg_t;

  typedef enum {PROG_IDLE, PROG_COUNT} ppc_prog_t;

endpackage

// ---- hw/ppc_programmer.sv ----
// Module: pin / emulation configuration decode and PA cap pulse programmer
`timescale 1ns/1ps

// How it works
// [R01] Power pins pick 0, 3, 6, 10 dB
// [R02] Deviation pin low 16 kHz, high 50 kHz
// [R03] Controller: enable low, code set, 1-32 pulses
// [R04] First pulse clears counter, latches frequency code
// [R05] Later pulses increment; code equals pulses minus one
// [R06] Enable rise commits count with latched code
// [R07] Cap applied only on matching code, else zero
// [R08] Controller programs the capacitor once only; the module accepts repeats, each new sequence overwriting the stored pair
// [R09] Controller holds frequency pins low for emulation
// [R10] Register bit 7 enables emulation, replaces pins
// [R11] Register bit 6 selects modulation
// [R12] Register bits 5:4 select output power
// [R13] Register bit 3 selects deviation
// [R14] Register bits 2:0 supply frequency code
// [R15] Pulse programming also works in emulation
// [R16] Software may write capacitor field directly
// [R17] In emulation, nonzero register capacitor overrides counted value
// [R18] Any frequency pin high means manual mode
// [R19] Modulation input low ASK, high FSK
// [R20] Nonzero code picks fixed divide ratio
// [R21] Counter saturates; stored value persists
module ppc_programmer #(
  parameter int MAX_PULSES = ppc_pkg::PULSE_MAX
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             modulation_select_pin,
  input  wire logic             power_select_hi_pin,
  input  wire logic             power_select_lo_pin,
  input  wire logic             deviation_select_pin,
  input  wire logic             freq_code_bit0_pin,
  input  wire logic             freq_code_bit1_pin,
  input  wire logic             freq_code_bit2_pin,
  input  wire logic             enablePin,
  input  wire logic             dataPin,
  input  wire logic             emuCfgWrEn,
  input  wire logic [7:0]       emuCfgWrData,
  input  wire logic             capRegWrEn,
  input  wire logic [4:0]       capRegWrData,
  output logic      [7:0]       emuCfgRd,
  output logic      [4:0]       capRegRd,
  output logic                  manualMode,
  output logic                  emuMode,
  output logic                  serialMode,
  output ppc_pkg::ppc_cfg_t     txCfg,
  output logic      [3:0]       attenDb,
  output logic      [5:0]       devKhz,
  output logic      [23:0]      divRatio,
  output logic      [4:0]       paCap,
  output logic      [4:0]       capStored,
  output logic      [2:0]       capFreq,
  output logic                  capValid
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Counter is five bits wide; more pulses than that cannot be held
  if (MAX_PULSES < 2 || MAX_PULSES > ppc_pkg::PULSE_MAX) begin : g_bad
    $error("MAX_PULSES must lie in 2..32");
  end

  localparam logic [4:0] CNT_TOP = 5'(MAX_PULSES - 1);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] attenOf(input logic [1:0] pwr);
    case (pwr)
      2'h0:    attenOf = ppc_pkg::ATTEN_00;
      2'h1:    attenOf = ppc_pkg::ATTEN_01;
      2'h2:    attenOf = ppc_pkg::ATTEN_10;
      default: attenOf = ppc_pkg::ATTEN_11;
    endcase
  endfunction

  function automatic logic [23:0] divOf(input logic [2:0] freq);
    case (freq)
      3'h1:    divOf = ppc_pkg::DIV_001;
      3'h2:    divOf = ppc_pkg::DIV_010;
      3'h3:    divOf = ppc_pkg::DIV_011;
      3'h4:    divOf = ppc_pkg::DIV_100;
      3'h5:    divOf = ppc_pkg::DIV_101;
      3'h6:    divOf = ppc_pkg::DIV_110;
      3'h7:    divOf = ppc_pkg::DIV_111;
      default: divOf = ppc_pkg::DIV_SERIAL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]          emuCfg_q;
  logic [4:0]          capReg_q;
  logic                dataPrev_q;
  logic                enPrev_q;
  ppc_pkg::ppc_prog_t  prog_q;
  ppc_pkg::ppc_prog_t  prog_d;
  logic [4:0]          pulseCnt_q;
  logic [4:0]          pulseCnt_d;
  logic [2:0]          latchFreq_q;
  logic [2:0]          latchFreq_d;
  logic [4:0]          capStored_q;
  logic [2:0]          capFreq_q;
  logic                capValid_q;
  logic                manual_q;
  logic                emu_q;
  logic                serial_q;
  ppc_pkg::ppc_cfg_t   txCfg_q;
  logic [3:0]          atten_q;
  logic [5:0]          dev_q;
  logic [23:0]         div_q;
  logic [4:0]          paCap_q;

  // ----------------------------------------------------------------
  // Mode and configuration selection
  // ----------------------------------------------------------------
  ppc_pkg::ppc_cfg_t pinCfg;
  ppc_pkg::ppc_cfg_t regCfg;
  ppc_pkg::ppc_cfg_t effCfg;
  wire logic [2:0] pinFreq = {freq_code_bit2_pin, freq_code_bit1_pin,
                              freq_code_bit0_pin};
  wire logic manualNow = |pinFreq;                              // R18
  // Emulation needs the frequency pins all low                 // R09
  wire logic emuNow = !manualNow && emuCfg_q[ppc_pkg::EMU_EN_BIT]; // R10

  assign pinCfg = '{modFsk:  modulation_select_pin,             // R19
                    pwr:     {power_select_hi_pin, power_select_lo_pin},
                    devHigh: deviation_select_pin,
                    freq:    pinFreq};
  // Register bits 6:0 map field for field onto the pins  // R11 R12 R13 R14
  assign regCfg = ppc_pkg::ppc_cfg_t'(
                    emuCfg_q[ppc_pkg::EMU_CFG_HI:ppc_pkg::EMU_CFG_LO]);
  // Plain serial mode leaves the pin-style settings at zero
  assign effCfg = manualNow ? pinCfg :
                  emuNow    ? regCfg : '0;                      // R10

  // ----------------------------------------------------------------
  // Pulse programming sequence
  // ----------------------------------------------------------------
  wire logic dataRise = dataPin && !dataPrev_q;
  wire logic enRise   = enablePin && !enPrev_q;
  // Pulses count only with enable low, manual or emulation   // R03 R15
  wire logic progArm  = (manualNow || emuNow) && !enablePin;
  wire logic cntSat   = (pulseCnt_q == CNT_TOP);

  always_comb begin
    prog_d      = prog_q;
    pulseCnt_d  = pulseCnt_q;
    latchFreq_d = latchFreq_q;
    case (prog_q)
      ppc_pkg::PROG_IDLE: begin
        if (progArm && dataRise) begin
          pulseCnt_d  = ppc_pkg::CAP_ZERO;                      // R04
          latchFreq_d = effCfg.freq;                            // R04
          prog_d      = ppc_pkg::PROG_COUNT;
        end
      end
      ppc_pkg::PROG_COUNT: begin
        if (enRise) begin
          prog_d = ppc_pkg::PROG_IDLE;                          // R06
        end else if (progArm && dataRise && !cntSat) begin
          pulseCnt_d = pulseCnt_q + 5'h01;                      // R05
        end
      end
      default: prog_d = ppc_pkg::PROG_IDLE;
    endcase
  end

  wire logic commit = (prog_q == ppc_pkg::PROG_COUNT) && enRise;

  // ----------------------------------------------------------------
  // Capacitor applied to the PA
  // ----------------------------------------------------------------
  wire logic regCapOn = emuNow && (capReg_q != ppc_pkg::CAP_ZERO); // R17
  wire logic freqHit  = capValid_q && (effCfg.freq == capFreq_q)
                        && (effCfg.freq != 3'h0);
  wire logic [4:0] paCapNext = regCapOn ? capReg_q :            // R16 R17
                               freqHit  ? capStored_q :         // R07
                               ppc_pkg::CAP_ZERO;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      emuCfg_q   <= ppc_pkg::EMU_CFG_RST;
      capReg_q   <= ppc_pkg::CAPREG_RST;
      dataPrev_q <= 1'b0;
      enPrev_q   <= 1'b0;
    end else begin
      if (emuCfgWrEn) emuCfg_q <= emuCfgWrData;                 // R10
      if (capRegWrEn) capReg_q <= capRegWrData;                 // R16
      dataPrev_q <= dataPin;
      enPrev_q   <= enablePin;
    end
  end

  // Held until the next sequence; rst stands for power loss   // R21
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_q      <= ppc_pkg::PROG_IDLE;
      pulseCnt_q  <= ppc_pkg::CAP_ZERO;
      latchFreq_q <= 3'h0;
      capStored_q <= ppc_pkg::CAP_ZERO;
      capFreq_q   <= 3'h0;
      capValid_q  <= 1'b0;
    end else begin
      prog_q      <= prog_d;
      pulseCnt_q  <= pulseCnt_d;
      latchFreq_q <= latchFreq_d;
      // A repeated sequence simply overwrites the stored pair  // R08
      if (commit) begin
        capStored_q <= pulseCnt_q;                              // R06
        capFreq_q   <= latchFreq_q;                             // R06
        capValid_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manual_q <= 1'b0;
      emu_q    <= 1'b0;
      serial_q <= 1'b1;
      txCfg_q  <= '0;
      atten_q  <= ppc_pkg::ATTEN_00;
      dev_q    <= ppc_pkg::DEV_LOW_KHZ;
      div_q    <= ppc_pkg::DIV_SERIAL;
      paCap_q  <= ppc_pkg::CAP_ZERO;
    end else begin
      manual_q <= manualNow;                                    // R18
      emu_q    <= emuNow;
      serial_q <= !manualNow;
      txCfg_q  <= effCfg;
      atten_q  <= attenOf(effCfg.pwr);                          // R01
      dev_q    <= effCfg.devHigh ? ppc_pkg::DEV_HIGH_KHZ
                                 : ppc_pkg::DEV_LOW_KHZ;        // R02
      div_q    <= divOf(effCfg.freq);                           // R20
      paCap_q  <= paCapNext;
    end
  end

  assign emuCfgRd   = emuCfg_q;
  assign capRegRd   = capReg_q;
  assign manualMode = manual_q;
  assign emuMode    = emu_q;
  assign serialMode = serial_q;
  assign txCfg      = txCfg_q;
  assign attenDb    = atten_q;
  assign devKhz     = dev_q;
  assign divRatio   = div_q;
  assign paCap      = paCap_q;
  assign capStored  = capStored_q;
  assign capFreq    = capFreq_q;
  assign capValid   = capValid_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_firstPulse;
    prog_q == ppc_pkg::PROG_IDLE && progArm && dataRise;
  endsequence

  sequence s_countPulse;
    prog_q == ppc_pkg::PROG_COUNT && !enRise && progArm && dataRise;
  endsequence

  sequence s_commit;
    prog_q == ppc_pkg::PROG_COUNT && enRise;
  endsequence

  property p_atten;
    txCfg_q.pwr == 2'h3 |-> atten_q == ppc_pkg::ATTEN_11;
  endproperty
  a_atten: assert property (p_atten) else $error("attenuation wrong"); // R01

  property p_attenLow;
    ##1 $past(effCfg.pwr) == 2'h2 |-> atten_q == ppc_pkg::ATTEN_10;
  endproperty
  a_attenLow: assert property (p_attenLow) else $error("6 dB lost"); // R01

  property p_dev;
    txCfg_q.devHigh ? dev_q == ppc_pkg::DEV_HIGH_KHZ
                    : dev_q == ppc_pkg::DEV_LOW_KHZ;
  endproperty
  a_dev: assert property (p_dev) else $error("deviation wrong"); // R02

  property p_first;
    s_firstPulse |=> prog_q == ppc_pkg::PROG_COUNT &&
      pulseCnt_q == ppc_pkg::CAP_ZERO && latchFreq_q == $past(effCfg.freq);
  endproperty
  a_first: assert property (p_first) else $error("first pulse"); // R04

  property p_count;
    s_countPulse ##0 !cntSat |=> pulseCnt_q == $past(pulseCnt_q) + 5'h01;
  endproperty
  a_count: assert property (p_count) else $error("count step"); // R05

  property p_commit;
    s_commit |=> capValid_q && capStored_q == $past(pulseCnt_q) &&
      capFreq_q == $past(latchFreq_q) && prog_q == ppc_pkg::PROG_IDLE;
  endproperty
  a_commit: assert property (p_commit) else $error("commit"); // R06

  property p_noMatch;
    !regCapOn && effCfg.freq != capFreq_q |=> paCap_q == ppc_pkg::CAP_ZERO;
  endproperty
  a_noMatch: assert property (p_noMatch) else $error("cap leak"); // R07

  property p_emuCfg;
    emuNow |=> emu_q && txCfg_q == $past(regCfg);
  endproperty
  a_emuCfg: assert property (p_emuCfg) else $error("emulation"); // R10

  property p_regCap;
    regCapOn |=> paCap_q == $past(capReg_q);
  endproperty
  a_regCap: assert property (p_regCap) else $error("reg cap"); // R17

  property p_manual;
    manualNow |=> manual_q && !emu_q && txCfg_q.freq == $past(pinFreq);
  endproperty
  a_manual: assert property (p_manual) else $error("manual mode"); // R18

  property p_div;
    txCfg_q.freq == 3'h7 |-> div_q == ppc_pkg::DIV_111;
  endproperty
  a_div: assert property (p_div) else $error("divide ratio"); // R20

  property p_sat;
    s_countPulse ##0 cntSat |=> pulseCnt_q == CNT_TOP;
  endproperty
  a_sat: assert property (p_sat) else $error("saturation"); // R21

endmodule

// ---- testbench/ppc_pin_ctrl.sv ----
// Controller model that drives the manual configuration pins
`timescale 1ns/1ps

module ppc_pin_ctrl (
  input  wire logic clk,
  output logic      modulation_select_pin,
  output logic      power_select_hi_pin,
  output logic      power_select_lo_pin,
  output logic      deviation_select_pin,
  output logic      freq_code_bit0_pin,
  output logic      freq_code_bit1_pin,
  output logic      freq_code_bit2_pin,
  output logic      enablePin,
  output logic      dataPin
);
  // ----------------------------------------------------------------
  // Idle state: pulled-down pins low, enable parked high
  // ----------------------------------------------------------------
  initial begin
    modulation_select_pin = 1'b0;
    power_select_hi_pin   = 1'b0;
    power_select_lo_pin   = 1'b0;
    deviation_select_pin  = 1'b0;
    freq_code_bit0_pin    = 1'b0;
    freq_code_bit1_pin    = 1'b0;
    freq_code_bit2_pin    = 1'b0;
    enablePin             = 1'b1;
    dataPin               = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pin tasks
  // ----------------------------------------------------------------
  // All-zero code keeps the device in serial mode for emulation
  task automatic setPins(input ppc_pkg::ppc_cfg_t cfg);
    @(posedge clk);
    modulation_select_pin <= cfg.modFsk;
    power_select_hi_pin   <= cfg.pwr[1];
    power_select_lo_pin   <= cfg.pwr[0];
    deviation_select_pin  <= cfg.devHigh;
    freq_code_bit0_pin    <= cfg.freq[0];
    freq_code_bit1_pin    <= cfg.freq[1];
    freq_code_bit2_pin    <= cfg.freq[2];
  endtask

  // Two cycles per level so the sampled edge detector sees each one
  task automatic pulseData(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge clk);
      dataPin <= 1'b1;
      repeat (2) @(posedge clk);
      dataPin <= 1'b0;
    end
  endtask

  // Each call stands for one fresh configuration of the part
  task automatic programCap(input int n);
    @(posedge clk);
    enablePin <= 1'b0;
    pulseData(n);
    repeat (2) @(posedge clk);
    enablePin <= 1'b1;
  endtask
endmodule

// ---- testbench/ppc_programmer_tb_top.sv ----
// Self-checking bench of the pin configuration and cap programmer
`timescale 1ns/1ps

module ppc_programmer_tb_top;
  logic clk, rst, modulation_select_pin, power_select_hi_pin;
  logic power_select_lo_pin, deviation_select_pin, freq_code_bit0_pin;
  logic freq_code_bit1_pin, freq_code_bit2_pin, enablePin, dataPin;
  logic emuCfgWrEn, capRegWrEn, manualMode, emuMode, serialMode, capValid;
  logic [7:0]  emuCfgWrData, emuCfgRd;
  logic [4:0]  capRegWrData, capRegRd, paCap, capStored;
  logic [3:0]  attenDb;
  logic [5:0]  devKhz;
  logic [23:0] divRatio;
  logic [2:0]  capFreq;
  ppc_pkg::ppc_cfg_t txCfg, cfg;
  int          errors, samplesChecked;
  int          counts[3] = '{1, 32, 35};

  ppc_programmer ppc_programmer_inst (
    .clk(clk), .rst(rst), .modulation_select_pin(modulation_select_pin),
    .power_select_hi_pin(power_select_hi_pin),
    .power_select_lo_pin(power_select_lo_pin),
    .deviation_select_pin(deviation_select_pin),
    .freq_code_bit0_pin(freq_code_bit0_pin),
    .freq_code_bit1_pin(freq_code_bit1_pin),
    .freq_code_bit2_pin(freq_code_bit2_pin),
    .enablePin(enablePin), .dataPin(dataPin), .emuCfgWrEn(emuCfgWrEn),
    .emuCfgWrData(emuCfgWrData), .capRegWrEn(capRegWrEn),
    .capRegWrData(capRegWrData), .emuCfgRd(emuCfgRd), .capRegRd(capRegRd),
    .manualMode(manualMode), .emuMode(emuMode), .serialMode(serialMode),
    .txCfg(txCfg), .attenDb(attenDb), .devKhz(devKhz),
    .divRatio(divRatio), .paCap(paCap), .capStored(capStored),
    .capFreq(capFreq), .capValid(capValid)
  );

  ppc_pin_ctrl ppc_pin_ctrl_inst (
    .clk(clk), .modulation_select_pin(modulation_select_pin),
    .power_select_hi_pin(power_select_hi_pin),
    .power_select_lo_pin(power_select_lo_pin),
    .deviation_select_pin(deviation_select_pin),
    .freq_code_bit0_pin(freq_code_bit0_pin),
    .freq_code_bit1_pin(freq_code_bit1_pin),
    .freq_code_bit2_pin(freq_code_bit2_pin),
    .enablePin(enablePin), .dataPin(dataPin)
  );

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Expected-value tables and helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] attenExp(input logic [1:0] p);
    case (p)
      2'h0:    return 4'h0;
      2'h1:    return 4'h3;
      2'h2:    return 4'h6;
      default: return 4'hA;
    endcase
  endfunction

  function automatic logic [23:0] divExp(input logic [2:0] f);
    case (f)
      3'h1:    return ppc_pkg::DIV_001;
      3'h2:    return ppc_pkg::DIV_010;
      3'h3:    return ppc_pkg::DIV_011;
      3'h4:    return ppc_pkg::DIV_100;
      3'h5:    return ppc_pkg::DIV_101;
      3'h6:    return ppc_pkg::DIV_110;
      3'h7:    return ppc_pkg::DIV_111;
      default: return ppc_pkg::DIV_SERIAL;
    endcase
  endfunction

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic checkCfg(input ppc_pkg::ppc_cfg_t e);
    check("txCfg", 24'(txCfg), 24'(e));
    check("attenDb", 24'(attenDb), 24'(attenExp(e.pwr)));
    check("devKhz", 24'(devKhz), e.devHigh ? 24'h32 : 24'h10);
    check("divRatio", divRatio, divExp(e.freq));
  endtask

  task automatic writeEmu(input logic [7:0] d);
    @(posedge clk);
    emuCfgWrEn   <= 1'b1;
    emuCfgWrData <= d;
    @(posedge clk);
    emuCfgWrEn   <= 1'b0;
    settle(3);
  endtask

  task automatic writeCap(input logic [4:0] d);
    @(posedge clk);
    capRegWrEn   <= 1'b1;
    capRegWrData <= d;
    @(posedge clk);
    capRegWrEn   <= 1'b0;
    settle(3);
  endtask

  task automatic giveVerdict();
    $display("checks %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    giveVerdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    emuCfgWrEn = 1'b0;
    emuCfgWrData = 8'h00;
    capRegWrEn = 1'b0;
    capRegWrData = 5'h00;
    errors = 0;
    samplesChecked = 0;
    settle(11);
    check("serialMode", 24'(serialMode), 24'h1);
    check("devKhz", 24'(devKhz), 24'h10);
    check("capValid", 24'(capValid), 24'h0);
    check("emuCfgRd", 24'(emuCfgRd), 24'h0);
    @(posedge clk);
    rst <= 1'b0;
    // Every code with power, deviation and modulation varied alongside
    for (int i = 0; i < 8; i++) begin
      cfg = {i[1], i[1:0], i[0], i[2:0]};
      ppc_pin_ctrl_inst.setPins(cfg);
      settle(3);
      check("manualMode", 24'(manualMode), 24'(i != 0));
      check("serialMode", 24'(serialMode), 24'(i == 0));
      checkCfg(i != 0 ? cfg : 7'h00);
    end
    // Classic sequence: eleven pulses give code ten on code 001
    ppc_pin_ctrl_inst.setPins(7'h01);
    ppc_pin_ctrl_inst.programCap(11);
    settle(4);
    check("capStored", 24'(capStored), 24'hA);
    check("capFreq", 24'(capFreq), 24'h1);
    check("capValid", 24'(capValid), 24'h1);
    check("paCap", 24'(paCap), 24'hA);
    ppc_pin_ctrl_inst.setPins(7'h07);
    settle(3);
    check("paCap", 24'(paCap), 24'h0);
    // Boundary counts, including more pulses than allowed
    foreach (counts[k]) begin
      ppc_pin_ctrl_inst.programCap(counts[k]);
      settle(4);
      check("capStored", 24'(capStored),
            24'(counts[k] > 32 ? 31 : counts[k] - 1));
      check("paCap", 24'(paCap),
            24'(counts[k] > 32 ? 31 : counts[k] - 1));
    end
    // Pulses while enable is high must not disturb the stored code
    ppc_pin_ctrl_inst.pulseData(3);
    settle(4);
    check("capStored", 24'(capStored), 24'h1F);
    // Emulation: frequency pins low, register takes over
    // Non-frequency pins high: the register must win over them
    ppc_pin_ctrl_inst.setPins(7'h78);
    settle(3);
    checkCfg(7'h00);
    for (int i = 0; i < 8; i++) begin
      writeEmu({1'b1, i[0], i[2:1], i[1], i[2:0]});
      check("emuCfgRd", 24'(emuCfgRd), 24'(emuCfgWrData));
      check("emuMode", 24'(emuMode), 24'h1);
      checkCfg(emuCfgWrData[6:0]);
    end
    writeEmu(8'h83);
    ppc_pin_ctrl_inst.programCap(6);
    settle(4);
    check("capStored", 24'(capStored), 24'h5);
    check("capFreq", 24'(capFreq), 24'h3);
    check("paCap", 24'(paCap), 24'h5);
    writeCap(5'h12);
    check("capRegRd", 24'(capRegRd), 24'h12);
    check("paCap", 24'(paCap), 24'h12);
    writeEmu(8'h81);
    check("paCap", 24'(paCap), 24'h12);
    writeCap(5'h00);
    check("paCap", 24'(paCap), 24'h0);
    writeEmu(8'h83);
    check("paCap", 24'(paCap), 24'h5);
    writeEmu(8'h03);
    check("emuMode", 24'(emuMode), 24'h0);
    checkCfg(7'h00);
    // Power loss drops the stored capacitor
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    check("capValid", 24'(capValid), 24'h0);
    check("capStored", 24'(capStored), 24'h0);
    giveVerdict();
  end
endmodule
